// ===== include/isf_map.vh
// Register offsets, field positions, reset values and codes of the source/filter bank.
`ifndef ISF_MAP_VH
`define ISF_MAP_VH

// ============================================================
// Register offsets (byte addresses on the register port)
// ============================================================
`define ISF_ADDR_THD_CTRL 8'h0d
`define ISF_ADDR_SRC_CFG 8'h15
`define ISF_ADDR_C2_LO 8'h16
`define ISF_ADDR_C2_HI 8'h17
`define ISF_ADDR_C3_LO 8'h18
`define ISF_ADDR_C3_HI 8'h19

// ============================================================
// Reset values
// ============================================================
`define ISF_RST_SRC_CFG 8'h00
`define ISF_RST_THD_CTRL 8'h40
`define ISF_RST_COEF 16'h0000
`define ISF_UNMAPPED_READ 8'h00

// ============================================================
// Field positions of the source and filter configuration
// ============================================================
`define ISF_HIGH_SRC_MSB 7
`define ISF_HIGH_SRC_LSB 6
`define ISF_LOW_SRC_MSB 5
`define ISF_LOW_SRC_LSB 4
`define ISF_IIR_SKIP_BIT 2
`define ISF_OSF_SKIP_BIT 0
`define ISF_THD_SKIP_BIT 6

// ============================================================
// Codes
// ============================================================
`define ISF_PIN_CFG_SELECTOR 4'h9
`define ISF_SRC_PCM 2'h0
`define ISF_SRC_SPDIF 2'h1
`define ISF_SRC_RESERVED 2'h2
`define ISF_SRC_DSD 2'h3
`define ISF_NUM_PINS 2
`define ISF_FRAC_BITS 15

`endif

// ===== hdl/isf_pin_sync.v
// Three-stage synchroniser with agreement filter for one selector pin.
`timescale 1ns/10ps
`default_nettype none

module isf_pin_sync (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Asynchronous pin and its clean level
  input wire pin_in,
  output wire level_out
);

  reg meta_reg;
  reg stage2_reg;
  reg stage3_reg;
  reg level_reg;

  // ============================================================
  // Synchroniser chain
  // ============================================================
  // The first stage feeds only the second; nothing else looks at it.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      stage2_reg <= meta_reg;
      stage3_reg <= stage2_reg;
      // A change counts only once the two later stages agree.
      if (stage2_reg == stage3_reg) begin
        level_reg <= stage3_reg;
      end
    end
  end

  assign level_out = level_reg;

endmodule // isf_pin_sync

`default_nettype wire

// ===== hdl/isf_regs.v
// Source selection, filter skip and harmonic compensation register bank.
//
// Overview of operation
// - Selector pin high: use high-level field; 0 PCM, 1 SPDIF, 3 DSD.
// - Selector pin low: use low-level field with the same source coding.
// - IIR skip bit 0 uses the IIR filter; 1 routes around it.
// - Interpolator skip bit 0 uses the 8x FIR; 1 bypasses it.
// - A pin acts as selector only when its config field holds 9.
// - With several selector pins, only the first one is obeyed.
// - Config register resets to zero: PCM sources, both filters in use.
// - Coefficients are signed 16-bit over byte pairs, high byte upper.
// - Both coefficients reset to zero, meaning no compensation.
// - Compensation on: out = x + x^2*c2 + x^3*c3.
// - Compensation skipped (default): out = x for PCM, x/2 for DSD.
`timescale 1ns/10ps
`default_nettype none
`include "isf_map.vh"

module isf_regs (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Byte register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rvalid_out,
  // Pin configuration fields and selector pins
  input wire [7:0] pin_cfg_in,
  input wire [1:0] selector_pin_in,
  // Routing controls
  output reg [1:0] source_sel_out,
  output reg iir_skip_out,
  output reg osf_skip_out,
  output reg [15:0] second_order_coefficient_out,
  output reg [15:0] third_order_coefficient_out,
  // Sample path
  input wire sample_valid_in,
  input wire [15:0] sample_in,
  input wire dsd_mode_in,
  output reg sample_valid_out,
  output reg [15:0] sample_out
);

  // ============================================================
  // Register storage
  // ============================================================
  reg [7:0] src_cfg_reg;
  reg [7:0] thd_ctrl_reg;
  reg [15:0] c2_reg;
  reg [15:0] c3_reg;

  // Register writes; reserved config bits are stored as written.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      src_cfg_reg <= `ISF_RST_SRC_CFG;
      thd_ctrl_reg <= `ISF_RST_THD_CTRL;
      c2_reg <= `ISF_RST_COEF;
      c3_reg <= `ISF_RST_COEF;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ISF_ADDR_SRC_CFG: src_cfg_reg <= reg_wdata_in;
        `ISF_ADDR_THD_CTRL: thd_ctrl_reg <= reg_wdata_in &
          (8'h01 << `ISF_THD_SKIP_BIT);
        // Each byte of a coefficient lands in its own half.
        `ISF_ADDR_C2_LO: c2_reg[7:0] <= reg_wdata_in;
        `ISF_ADDR_C2_HI: c2_reg[15:8] <= reg_wdata_in;
        `ISF_ADDR_C3_LO: c3_reg[7:0] <= reg_wdata_in;
        `ISF_ADDR_C3_HI: c3_reg[15:8] <= reg_wdata_in;
        default: src_cfg_reg <= src_cfg_reg;
      endcase
    end
  end

  // Read decode is shared by the read path; unmapped reads return zero.
  function [7:0] read_mux;
    input [7:0] addr;
    input [7:0] cfg;
    input [7:0] thd;
    input [15:0] c2;
    input [15:0] c3;
    begin
      case (addr)
        `ISF_ADDR_SRC_CFG: read_mux = cfg;
        `ISF_ADDR_THD_CTRL: read_mux = thd;
        `ISF_ADDR_C2_LO: read_mux = c2[7:0];
        `ISF_ADDR_C2_HI: read_mux = c2[15:8];
        `ISF_ADDR_C3_LO: read_mux = c3[7:0];
        `ISF_ADDR_C3_HI: read_mux = c3[15:8];
        default: read_mux = `ISF_UNMAPPED_READ;
      endcase
    end
  endfunction

  // Read data is registered and marked valid one cycle after the strobe.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= read_mux(reg_addr_in, src_cfg_reg, thd_ctrl_reg,
          c2_reg, c3_reg);
      end
    end
  end

  // ============================================================
  // Selector pins
  // ============================================================
  wire [1:0] pin_level;

  genvar gi;
  generate
    for (gi = 0; gi < `ISF_NUM_PINS; gi = gi + 1) begin : g_pin
      isf_pin_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(selector_pin_in[gi]),
        .level_out(pin_level[gi])
      );
    end
  endgenerate

  wire pin0_is_sel = (pin_cfg_in[3:0] == `ISF_PIN_CFG_SELECTOR);
  wire pin1_is_sel = (pin_cfg_in[7:4] == `ISF_PIN_CFG_SELECTOR);

  // Pin 0 wins whenever both are selectors; with none, the level reads low.
  reg sel_level;
  always @* begin
    if (pin0_is_sel) begin
      sel_level = pin_level[0];
    end else if (pin1_is_sel) begin
      sel_level = pin_level[1];
    end else begin
      sel_level = 1'b0;
    end
  end

  // ============================================================
  // Routing controls
  // ============================================================
  // The reserved source code is passed on unchanged; the datapath decides.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      source_sel_out <= `ISF_SRC_PCM;
      iir_skip_out <= 1'b0;
      osf_skip_out <= 1'b0;
      second_order_coefficient_out <= `ISF_RST_COEF;
      third_order_coefficient_out <= `ISF_RST_COEF;
    end else begin
      if (sel_level) begin
        source_sel_out <= src_cfg_reg[`ISF_HIGH_SRC_MSB:`ISF_HIGH_SRC_LSB];
      end else begin
        source_sel_out <= src_cfg_reg[`ISF_LOW_SRC_MSB:`ISF_LOW_SRC_LSB];
      end
      iir_skip_out <= src_cfg_reg[`ISF_IIR_SKIP_BIT];
      // Skipping the interpolator assumes 8x oversampled input.
      osf_skip_out <= src_cfg_reg[`ISF_OSF_SKIP_BIT];
      second_order_coefficient_out <= c2_reg;
      third_order_coefficient_out <= c3_reg;
    end
  end

  // ============================================================
  // Harmonic compensation
  // ============================================================
  // Samples and coefficients are Q1.15; each product is rescaled by 2^-15.
  wire signed [15:0] x = sample_in;
  wire signed [15:0] c2 = c2_reg;
  wire signed [15:0] c3 = c3_reg;
  wire signed [31:0] sq_full = x * x;
  wire signed [16:0] sq = sq_full[31:15];
  wire signed [32:0] cube_full = sq * x;
  wire signed [17:0] cube = cube_full[32:15];
  wire signed [32:0] t2_full = sq * c2;
  wire signed [17:0] t2 = t2_full[32:15];
  wire signed [33:0] t3_full = cube * c3;
  wire signed [18:0] t3 = t3_full[33:15];
  wire signed [19:0] comp_sum = {{4{x[15]}}, x} + {{2{t2[17]}}, t2} +
    {t3[18], t3};

  // Saturation keeps an over-driven correction from wrapping sign.
  function [15:0] saturate;
    input [19:0] v;
    begin
      if (v[19] && (v[18:15] != 4'hf)) begin
        saturate = 16'h8000;
      end else if (!v[19] && (v[18:15] != 4'h0)) begin
        saturate = 16'h7fff;
      end else begin
        saturate = v[15:0];
      end
    end
  endfunction

  wire thd_skip = thd_ctrl_reg[`ISF_THD_SKIP_BIT];

  // One-cycle registered sample path.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      sample_valid_out <= 1'b0;
      sample_out <= 16'h0000;
    end else begin
      sample_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        if (!thd_skip) begin
          sample_out <= saturate(comp_sum);
        end else if (dsd_mode_in) begin
          sample_out <= {sample_in[15], sample_in[15:1]};
        end else begin
          sample_out <= sample_in;
        end
      end
    end
  end

endmodule // isf_regs

`default_nettype wire

// ===== sim/isf_regs_monitor.sv
// Checker of the source and filter register bank ports.
`timescale 1ns/10ps
`default_nettype none
module isf_regs_monitor (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // Routing and sample path
  input wire logic iir_skip_out,
  input wire logic osf_skip_out,
  input wire logic [15:0] second_order_coefficient_out,
  input wire logic sample_valid_in,
  input wire logic sample_valid_out,
  input wire logic [15:0] sample_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ============================================================
  // Register port steps
  // ============================================================
  sequence s_cfg_wr;
    reg_wr_in && reg_addr_in == 8'h15;
  endsequence
  sequence s_cfg_rd;
    reg_rd_in && !reg_wr_in && reg_addr_in == 8'h15;
  endsequence
  a_iir_skip_follow: assert property (s_cfg_wr |-> ##2
    iir_skip_out == $past(reg_wdata_in[2], 2)) else $error("iir skip");
  a_osf_skip_follow: assert property (s_cfg_wr |-> ##2
    osf_skip_out == $past(reg_wdata_in[0], 2)) else $error("osf skip");
  // The bench leaves one idle cycle between a write and the next read.
  a_cfg_read_back: assert property (s_cfg_wr ##1 !reg_wr_in ##1 s_cfg_rd |=>
    reg_rdata_out == $past(reg_wdata_in, 3)) else $error("cfg read");
  a_coef_low_byte: assert property (reg_wr_in && reg_addr_in == 8'h16
    |-> ##2 second_order_coefficient_out[7:0] == $past(reg_wdata_in, 2))
    else $error("c2 low byte");
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("stray read valid");
  a_sample_strobe: assert property (sample_valid_in |=> sample_valid_out)
    else $error("sample valid lost");
  a_sample_hold: assert property (!sample_valid_in |=>
    !sample_valid_out && $stable(sample_out)) else $error("sample moved");
endmodule // isf_regs_monitor
bind isf_regs isf_regs_monitor mon (.*);
`default_nettype wire

// ===== sim/isf_mcu_model.sv
// Controller model that drives the selector pins.
`timescale 1ns/10ps
`default_nettype none
module isf_mcu_model (
  // Selector pin levels
  output var logic [1:0] selector_pin_out
);
  initial selector_pin_out = 2'h0;
  // Pins move off any clock edge, so the device has to synchronise them.
  task automatic set_pins(input logic [1:0] lv);
    #37 selector_pin_out = lv;
  endtask
endmodule // isf_mcu_model
`default_nettype wire

// ===== sim/tb_input_select_filter_bypass_thd_regs.sv
// Self-checking bench of the source and filter register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %0t %h %h", $time, a, e); end end
module tb_input_select_filter_bypass_thd_regs;
  logic clk_sys_in, rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, pin_cfg_in;
  logic [1:0] selector_pin_in, source_sel_out;
  logic iir_skip_out, osf_skip_out, sample_valid_in, dsd_mode_in;
  logic sample_valid_out;
  logic [15:0] second_order_coefficient_out, third_order_coefficient_out;
  logic [15:0] sample_in, sample_out;
  int fails = 0;
  int tests_run = 0;
  isf_regs uut (.*);
  isf_mcu_model mcu (.selector_pin_out(selector_pin_in));
  // Expected compensation result, saturated to 16 bits.
  function automatic logic [15:0] exp_comp(input logic signed [15:0] x,
      input logic signed [15:0] c2, input logic signed [15:0] c3);
    logic signed [47:0] sq, cu, s;
    sq = (x * x) >>> 15;
    cu = (sq * x) >>> 15;
    s = x + ((sq * c2) >>> 15) + ((cu * c3) >>> 15);
    if (s > 32767) s = 32767;
    else if (s < -32768) s = -32768;
    return s[15:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_sys_in);
    // The answer stands for one cycle only, so it is taken right here.
    d = reg_valid_data(reg_rvalid_out, reg_rdata_out);
    reg_rd_in = 1'b0;
  endtask
  // An absent valid poisons the data so the caller sees a mismatch.
  function automatic logic [7:0] reg_valid_data(input logic v,
      input logic [7:0] d);
    return (v === 1'b1) ? d : 8'hxx;
  endfunction
  // Samples come at the rate the enabled filters expect.
  // With the interpolator skipped each one stands for 8x oversampled data.
  task automatic smp(input logic [15:0] x, input logic [15:0] e);
    @(negedge clk_sys_in);
    sample_in = x;
    sample_valid_in = 1'b1;
    @(negedge clk_sys_in);
    sample_valid_in = 1'b0;
    `CHK(sample_out, e)
    `CHK(sample_valid_out, 1'b1)
  endtask
  task automatic pin_chk(input logic [7:0] c, input logic [1:0] lv,
      input logic [1:0] e);
    pin_cfg_in = c;
    mcu.set_pins(lv);
    repeat (7) @(negedge clk_sys_in);
    `CHK(source_sel_out, e)
  endtask
  task automatic conclude;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ============================================================
  // Clock and watchdog
  // ============================================================
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #2000000;
    fails++;
    conclude();
  end
  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    logic [7:0] d, cfg;
    logic [15:0] x, c2, c3;
    {reg_wr_in, reg_rd_in, sample_valid_in, dsd_mode_in} = 4'h0;
    {reg_addr_in, reg_wdata_in, pin_cfg_in} = 24'h000000;
    sample_in = 16'h0000;
    rst_in = 1'b1;
    void'($urandom(4));
    repeat (5) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd(8'h15, d); `CHK(d, 8'h00)
    rd(8'h0d, d); `CHK(d, 8'h40)
    for (int a = 8'h16; a < 8'h1a; a++) begin
      rd(a[7:0], d); `CHK(d, 8'h00)
    end
    rd(8'h00, d); `CHK(d, 8'h00)
    x = 16'($urandom);
    smp(x, x);
    dsd_mode_in = 1'b1;
    smp(x, 16'($signed(x) >>> 1));
    dsd_mode_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      cfg = {i[3:0], 4'h0} | 8'($urandom & 8'h05); // Bits 3, 1 kept low.
      wr(8'h15, cfg);
      rd(8'h15, d); `CHK(d, cfg)
      `CHK({iir_skip_out, osf_skip_out}, {cfg[2], cfg[0]})
      pin_chk(8'h09, 2'b01, cfg[7:6]);
      pin_chk(8'h09, 2'b00, cfg[5:4]);
    end
    wr(8'h15, 8'h70);
    pin_chk(8'h08, 2'b01, 2'd3);
    pin_chk(8'h90, 2'b10, 2'd1);
    pin_chk(8'h99, 2'b10, 2'd3);
    wr(8'h0d, 8'h00);
    smp(x, x);
    for (int i = 0; i < 8; i++) begin
      {c2, c3, x} = 48'({$urandom, $urandom});
      if (i == 0) {c2, c3, x} = 48'h8000_7fff_8000;
      wr(8'h16, c2[7:0]);
      wr(8'h17, c2[15:8]);
      wr(8'h18, c3[7:0]);
      wr(8'h19, c3[15:8]);
      @(negedge clk_sys_in);
      `CHK(second_order_coefficient_out, c2)
      `CHK(third_order_coefficient_out, c3)
      smp(x, exp_comp(x, c2, c3));
    end
    // A second reset in mid-run must bring config, THD control, c2 high byte and routing back to default.
    rst_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd(8'h15, d); `CHK(d, 8'h00)
    rd(8'h17, d); `CHK(d, 8'h00)
    rd(8'h0d, d); `CHK(d, 8'h40)
    `CHK({iir_skip_out, osf_skip_out}, 2'b00)
    `CHK(source_sel_out, 2'h0)
    smp(x, x);
    conclude();
  end
endmodule // tb_input_select_filter_bypass_thd_regs
`default_nettype wire
